// ---- inc/srxm_pkg.sv ----
// Package for the receive mailbox-to-queue mapper: register map, field layouts, codes.
// Assumes a 32-bit APB register bus and same-clock message request logic.
package srxm_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [11:0] SRXM_PTR_BASE  = 12'h600;
    localparam logic [11:0] SRXM_MAP_BASE  = 12'h800;
    localparam logic [11:0] SRXM_STAT_ADDR = 12'h900;
    localparam logic [11:0] SRXM_CAP_ADDR  = 12'h904;
    localparam logic [11:0] SRXM_BUSY_ADDR = 12'h908;

    // ==========================================================
    // Reset values
    localparam logic [1:0] SRXM_LMASK_RST = 2'h3;
    localparam logic [5:0] SRXM_MMASK_RST = 6'h3f;
    localparam logic [1:0] SRXM_TT_RST    = 2'h1;

    // ==========================================================
    // Field positions of the route register and of status
    localparam int SRXM_HI_TT_LSB = 8;
    localparam int SRXM_HI_Q_LSB  = 2;
    localparam int SRXM_HI_PROM   = 1;
    localparam int SRXM_HI_MULTI  = 0;
    localparam int SRXM_ST_SRC    = 0;
    localparam int SRXM_ST_PTR    = 1;
    localparam int SRXM_ST_MAP    = 2;

    // ==========================================================
    // Response codes
    localparam logic [3:0] SRXM_FTYPE_RESP = 4'hd;
    localparam logic [3:0] SRXM_ST_DONE    = 4'h0;
    localparam logic [3:0] SRXM_ST_RETRY   = 4'h3;
    localparam logic [3:0] SRXM_ST_ERROR   = 4'h7;

    // ==========================================================
    // Layouts
    typedef struct packed {
        logic [1:0]  lmask;
        logic [5:0]  mmask;
        logic [1:0]  letter;
        logic [5:0]  mbox;
        logic [15:0] src;
    } srxm_lo_t;

    typedef struct packed {
        logic [1:0] tt;
        logic [3:0] queue;
        logic       prom;
        logic       multi;
    } srxm_hi_t;

    typedef struct packed {
        logic [15:0] src_id;
        logic [3:0]  msglen;
        logic [3:0]  seg;
        logic [1:0]  mbox;
        logic [1:0]  letter;
    } srxm_req_t;

    typedef struct packed {
        logic [3:0]  ftype;
        logic [3:0]  status;
        logic [15:0] src_id;
        logic [3:0]  queue;
        logic [1:0]  mbox;
        logic [1:0]  letter;
        logic [3:0]  seg;
    } srxm_rsp_t;

    typedef struct packed {
        logic [3:0]  queue;
        logic [31:0] ptr;
    } srxm_take_t;

    typedef struct packed {
        logic [15:0] src;
        logic [1:0]  mbox;
        logic [1:0]  letter;
    } srxm_owner_t;

    typedef struct packed {
        logic [1:0]  letter;
        logic [5:0]  mbox;
        logic [15:0] src;
    } srxm_cap_t;

endpackage

// ---- design/srxm_mapper.sv ----
// Receive mailbox mapper: maps message requests to RX queues, answers each one.
// Assumes APB master on pclk and message requests, buffer events from pclk logic.
//
// Operation
// - Accept messages for all 64 mailboxes, handle them one at a time in order.
// - Single-packet messages use the segment field as four extra mailbox bits.
// - Queue choice comes from source ID, length, mailbox, letter and extended mailbox.
// - Thirty-two programmable mapping entries, each naming a target queue.
// - No matching entry means the message is dropped with an ERROR answer.
// - Mask bit zero removes that mailbox or letter bit from the compare.
// - Source ID mismatch gives ERROR, captures the request, raises an error event.
// - Promiscuous entry accepts any source but still applies mailbox and letter.
// - Non-promiscuous entry needs all sixteen source ID bits equal.
// - Single-segment entries compare six mailbox bits, multi-segment entries two.
// - Match register layout and reset: masks all ones, other fields zero.
// - Route register layout: transport type reset 01, queue, promiscuous, segment mode.
// - Exactly one buffer descriptor is taken per message.
// - A multi-segment queue takes one incoming message at a time.
// - Sixteen RX queues, each usable for single or multi-segment traffic.
// - Head pointer write starts a queue; exhausted buffers clear it to zero.
// - Writing a head pointer that is still nonzero flags an error and keeps the old value.
// - New multi-segment message to a busy queue gets a RETRY type 13 answer.
// - Duplicate from the owning source, mailbox and letter gets ERROR.
// - Queue never started or torn down gives an ERROR answer.

`timescale 1ns/1ps
`default_nettype none

module srxm_mapper
#(
    parameter int NUM_ENTRIES = 32,
    parameter int NUM_QUEUES  = 16,
    parameter int ADDR_W      = 12
)
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                req_valid,
    input  wire srxm_pkg::srxm_req_t req,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output var srxm_pkg::srxm_rsp_t  rsp,
    input  wire logic                rsp_ready,
    output logic                     take_valid,
    output var srxm_pkg::srxm_take_t take,
    input  wire logic                exh_valid,
    input  wire logic [3:0]          exh_queue,
    input  wire logic                rel_valid,
    input  wire logic [3:0]          rel_queue,
    output logic                     err_event
);
    import srxm_pkg::*;

    // ==========================================================
    // Elaboration checks
    if (NUM_ENTRIES < 1 || NUM_ENTRIES > 32 || NUM_QUEUES < 1 || NUM_QUEUES > 16 || ADDR_W < 12)
    begin : g_bad_params
        $error("srxm_mapper: unsupported parameter values");
    end

    // ==========================================================
    // State
    typedef struct packed {
        srxm_lo_t    [NUM_ENTRIES-1:0]      lo;
        srxm_hi_t    [NUM_ENTRIES-1:0]      hi;
        logic        [NUM_QUEUES-1:0][31:0] ptr;
        logic        [NUM_QUEUES-1:0]       busy;
        srxm_owner_t [NUM_QUEUES-1:0]       own;
        logic        [NUM_QUEUES-1:0][3:0]  nseg;
        logic                               rsp_valid;
        srxm_rsp_t                          rsp;
        logic                               take_valid;
        srxm_take_t                         take;
        logic        [2:0]                  stat;
        srxm_cap_t                          cap;
        logic                               err_event;
        logic        [31:0]                 prdata;
        logic                               slverr;
    } srxm_state_t;

    srxm_state_t cur;
    srxm_state_t next_cur;

    logic        acc;
    logic        d_single;
    logic [5:0]  d_mbox;
    logic        d_hit;
    logic        d_any;
    logic [3:0]  d_q;
    logic        d_qok;
    logic        d_busy;
    logic        d_same;
    logic        mm;
    logic        lm;
    logic [11:0] a;
    logic        a_ok;
    logic [31:0] a_rd;
    logic [31:0] hi_rd;
    logic        apb_wr;
    logic        apb_ptr_wr;
    logic [3:0]  w_q;
    logic [4:0]  w_e;

    // ==========================================================
    // Outputs
    assign req_ready  = !cur.rsp_valid || rsp_ready;
    assign acc        = req_valid && req_ready;
    assign rsp_valid  = cur.rsp_valid;
    assign rsp        = cur.rsp;
    assign take_valid = cur.take_valid;
    assign take       = cur.take;
    assign err_event  = cur.err_event;
    assign prdata     = cur.prdata;
    assign pready     = psel && penable;
    assign pslverr    = psel && penable && cur.slverr;

    // ==========================================================
    // Address decode
    always_comb
    begin
        a          = paddr[11:0];
        w_q        = a[5:2];
        w_e        = a[7:3];
        apb_wr     = psel && penable && pwrite;
        a_ok       = 1'b0;
        a_rd       = 32'h0000_0000;
        hi_rd      = 32'h0000_0000;
        apb_ptr_wr = 1'b0;
        if (int'(w_e) < NUM_ENTRIES)
        begin
            hi_rd[SRXM_HI_TT_LSB +: 2] = cur.hi[w_e].tt;
            hi_rd[SRXM_HI_Q_LSB +: 4]  = cur.hi[w_e].queue;
            hi_rd[SRXM_HI_PROM]        = cur.hi[w_e].prom;
            hi_rd[SRXM_HI_MULTI]       = cur.hi[w_e].multi;
        end
        if ((paddr >> 12) == '0 && a[1:0] == 2'h0)
        begin
            if (a[11:6] == SRXM_PTR_BASE[11:6] && int'(w_q) < NUM_QUEUES)
            begin
                a_ok       = 1'b1;
                a_rd       = cur.ptr[w_q];
                apb_ptr_wr = apb_wr;
            end
            else if (a[11:8] == SRXM_MAP_BASE[11:8] && int'(w_e) < NUM_ENTRIES)
            begin
                a_ok = 1'b1;
                a_rd = a[2] ? hi_rd : cur.lo[w_e];
            end
            else if (a == SRXM_STAT_ADDR)
            begin
                a_ok = 1'b1;
                a_rd = {29'h0, cur.stat};
            end
            else if (a == SRXM_CAP_ADDR)
            begin
                a_ok = 1'b1;
                a_rd = {8'h00, cur.cap};
            end
            else if (a == SRXM_BUSY_ADDR)
            begin
                a_ok = 1'b1;
                a_rd = 32'(cur.busy);
            end
        end
    end

    // ==========================================================
    // Mapping table lookup
    always_comb
    begin
        mm       = 1'b0;
        lm       = 1'b0;
        d_hit    = 1'b0;
        d_any    = 1'b0;
        d_q      = 4'h0;
        d_single = (req.msglen == 4'h0);
        d_mbox   = d_single ? {req.seg, req.mbox} : {4'h0, req.mbox};
        // Descending scan leaves the lowest matching index
        for (int i = NUM_ENTRIES - 1; i >= 0; i--)
        begin
            mm = d_single ? (((cur.lo[i].mbox ^ d_mbox) & cur.lo[i].mmask) == 6'h00)
                          : (((cur.lo[i].mbox[1:0] ^ req.mbox) & cur.lo[i].mmask[1:0]) == 2'h0);
            lm = ((cur.lo[i].letter ^ req.letter) & cur.lo[i].lmask) == 2'h0;
            if (cur.hi[i].multi == !d_single && mm && lm)
            begin
                d_any = 1'b1;
                if (cur.hi[i].prom || cur.lo[i].src == req.src_id)
                begin
                    d_hit = 1'b1;
                    d_q   = cur.hi[i].queue;
                end
            end
        end
        d_qok  = d_hit && int'(d_q) < NUM_QUEUES && cur.ptr[d_q] != 32'h0;
        d_busy = d_qok && cur.busy[d_q];
        d_same = d_qok && cur.own[d_q] == {req.src_id, req.mbox, req.letter};
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        next_cur            = cur;
        next_cur.take_valid = 1'b0;
        next_cur.err_event  = 1'b0;
        if (cur.rsp_valid && rsp_ready)
        begin
            next_cur.rsp_valid = 1'b0;
        end
        if (rel_valid && int'(rel_queue) < NUM_QUEUES)
        begin
            next_cur.busy[rel_queue] = 1'b0;
        end
        if (exh_valid && int'(exh_queue) < NUM_QUEUES)
        begin
            next_cur.ptr[exh_queue] = 32'h0;
        end
        if (psel && !penable)
        begin
            next_cur.prdata = a_rd;
            next_cur.slverr = !a_ok;
        end
        if (apb_wr && a_ok)
        begin
            if (apb_ptr_wr)
            begin
                if (cur.ptr[w_q] != 32'h0)
                begin
                    next_cur.stat[SRXM_ST_PTR] = 1'b1;
                end
                else
                begin
                    next_cur.ptr[w_q] = pwdata;
                end
            end
            else if (a[11:8] == SRXM_MAP_BASE[11:8] && !a[2])
            begin
                next_cur.lo[w_e] = srxm_lo_t'(pwdata);
            end
            else if (a[11:8] == SRXM_MAP_BASE[11:8])
            begin
                next_cur.hi[w_e].tt    = pwdata[SRXM_HI_TT_LSB +: 2];
                next_cur.hi[w_e].queue = pwdata[SRXM_HI_Q_LSB +: 4];
                next_cur.hi[w_e].prom  = pwdata[SRXM_HI_PROM];
                next_cur.hi[w_e].multi = pwdata[SRXM_HI_MULTI];
            end
            else if (a == SRXM_STAT_ADDR)
            begin
                next_cur.stat = cur.stat & ~pwdata[2:0];
            end
        end
        if (acc)
        begin
            next_cur.rsp_valid     = 1'b1;
            next_cur.rsp.ftype     = SRXM_FTYPE_RESP;
            next_cur.rsp.status    = SRXM_ST_ERROR;
            next_cur.rsp.src_id    = req.src_id;
            next_cur.rsp.queue     = d_q;
            next_cur.rsp.mbox      = req.mbox;
            next_cur.rsp.letter    = req.letter;
            next_cur.rsp.seg       = req.seg;
            next_cur.take.queue    = d_q;
            next_cur.take.ptr      = d_qok ? cur.ptr[d_q] : 32'h0;
            if (!d_hit)
            begin
                if (d_any)
                begin
                    next_cur.stat[SRXM_ST_SRC] = 1'b1;
                    next_cur.cap               = {req.letter, d_mbox, req.src_id};
                    next_cur.err_event         = 1'b1;
                end
                else
                begin
                    next_cur.stat[SRXM_ST_MAP] = 1'b1;
                end
            end
            else if (!d_qok)
            begin
                next_cur.rsp.status = SRXM_ST_ERROR;
            end
            else if (d_single)
            begin
                next_cur.rsp.status = SRXM_ST_DONE;
                next_cur.take_valid = 1'b1;
            end
            else if (d_busy)
            begin
                if (!d_same)
                begin
                    next_cur.rsp.status = SRXM_ST_RETRY;
                end
                else if (req.seg == cur.nseg[d_q])
                begin
                    next_cur.rsp.status = SRXM_ST_DONE;
                    next_cur.nseg[d_q]  = 4'(req.seg + 4'h1);
                    if (req.seg == req.msglen)
                    begin
                        next_cur.busy[d_q] = 1'b0;
                    end
                end
            end
            else if (req.seg == 4'h0)
            begin
                next_cur.rsp.status = SRXM_ST_DONE;
                next_cur.busy[d_q]  = 1'b1;
                next_cur.own[d_q]   = {req.src_id, req.mbox, req.letter};
                next_cur.nseg[d_q]  = 4'h1;
                next_cur.take_valid = 1'b1;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur <= '0;
            for (int i = 0; i < NUM_ENTRIES; i++)
            begin
                cur.lo[i].lmask <= SRXM_LMASK_RST;
                cur.lo[i].mmask <= SRXM_MMASK_RST;
                cur.hi[i].tt    <= SRXM_TT_RST;
            end
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_inorder_answer;
        acc |=> cur.rsp_valid && cur.rsp.src_id == $past(req.src_id) && cur.rsp.seg == $past(req.seg);
    endproperty
    a_inorder_answer: assert property (p_inorder_answer) else $error("request not answered next cycle");

    property p_unmapped_error;
        acc && !d_any |=> cur.rsp.status == SRXM_ST_ERROR && cur.stat[SRXM_ST_MAP];
    endproperty
    a_unmapped_error: assert property (p_unmapped_error) else $error("unmapped message not refused");

    property p_src_reject;
        acc && d_any && !d_hit |=> cur.rsp.status == SRXM_ST_ERROR && err_event
            ##1 (!err_event || $past(acc && d_any && !d_hit));
    endproperty
    a_src_reject: assert property (p_src_reject) else $error("source mismatch not reported");

    property p_queue_unset;
        acc && d_hit && !d_qok |=> cur.rsp.status == SRXM_ST_ERROR && !take_valid;
    endproperty
    a_queue_unset: assert property (p_queue_unset) else $error("stopped queue accepted message");

    property p_single_take;
        acc && d_qok && d_single |=> take_valid && take.queue == $past(d_q) && rsp.status == SRXM_ST_DONE;
    endproperty
    a_single_take: assert property (p_single_take) else $error("single message took no descriptor");

    property p_busy_retry;
        acc && d_busy && !d_same && !d_single |=> rsp.status == SRXM_ST_RETRY && rsp.ftype == 4'hd;
    endproperty
    a_busy_retry: assert property (p_busy_retry) else $error("busy queue did not retry");

    property p_dup_error;
        acc && d_busy && d_same && !d_single && req.seg != cur.nseg[d_q] |=> rsp.status == SRXM_ST_ERROR;
    endproperty
    a_dup_error: assert property (p_dup_error) else $error("duplicate segment not refused");

    property p_claim;
        acc && d_qok && !d_single && !d_busy && req.seg == 4'h0 |=> cur.busy[$past(d_q)] && take_valid;
    endproperty
    a_claim: assert property (p_claim) else $error("multi queue not claimed");

    property p_ptr_write_err;
        apb_ptr_wr && cur.ptr[w_q] != 32'h0 && !exh_valid |=> cur.stat[SRXM_ST_PTR] && $stable(cur.ptr);
    endproperty
    a_ptr_write_err: assert property (p_ptr_write_err) else $error("nonzero head write not flagged");

    property p_ptr_clear;
        exh_valid && int'(exh_queue) < NUM_QUEUES && !(apb_ptr_wr && w_q == exh_queue)
            |=> cur.ptr[$past(exh_queue)] == 32'h0;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("head pointer not cleared");

    c_single_done: cover property (acc && d_qok && d_single ##1 rsp.status == SRXM_ST_DONE);
    c_retry: cover property (acc && d_busy && !d_same && !d_single);
    c_multi_done: cover property (acc && d_busy && d_same && req.seg == req.msglen ##1 !cur.busy[$past(d_q)]);
    c_src_reject: cover property (acc && d_any && !d_hit);

endmodule

`default_nettype wire

// ---- test/srxm_ep_model.sv ----
// Remote endpoint model: sends message requests, takes responses.
// Assumes pclk logic on the far side of the mapper's message link.
`timescale 1ns/1ps
`default_nettype none

module srxm_ep_model
    import srxm_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                req_ready,
    input  wire logic                rsp_valid,
    input  wire srxm_pkg::srxm_rsp_t rsp,
    output logic                     req_valid,
    output var srxm_pkg::srxm_req_t  req,
    output logic                     rsp_ready
);
    initial
    begin
        req_valid = 1'b0;
        req       = '0;
        rsp_ready = 1'b1;
    end

    // ==========================================================
    // One request, one response; optional response stall
    task automatic send(input srxm_req_t r, input int stall, output srxm_rsp_t q);
        @(posedge pclk);
        req_valid <= 1'b1;
        req       <= r;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        req       <= ~r;
        if (stall > 0)
        begin
            rsp_ready <= 1'b0;
            repeat (stall) @(posedge pclk);
            rsp_ready <= 1'b1;
        end
        do @(posedge pclk); while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1));
        q = rsp;
    endtask
endmodule

`default_nettype wire

// ---- test/tb.sv ----
// Testbench for the receive mailbox mapper.
// Assumes the endpoint model and the srxm package.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import srxm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, req_valid, req_ready, rsp_valid, rsp_ready;
    srxm_req_t req;
    srxm_rsp_t rsp;
    srxm_take_t take, last_take;
    logic take_valid, err_event, slv;
    logic exh_valid = 1'b0, rel_valid = 1'b0;
    logic [3:0] exh_queue = '0, rel_queue = '0;
    logic [31:0] rd;
    int error_cnt = 0, compares = 0, takes = 0, errs = 0;

    always #20 pclk = ~pclk;

    srxm_mapper dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready), .take_valid(take_valid),
        .take(take), .exh_valid(exh_valid), .exh_queue(exh_queue), .rel_valid(rel_valid),
        .rel_queue(rel_queue), .err_event(err_event));

    srxm_ep_model ep (.pclk(pclk), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp(rsp), .req_valid(req_valid), .req(req), .rsp_ready(rsp_ready));

    // ==========================================================
    // Event monitor
    always @(posedge pclk)
    begin
        if (take_valid === 1'b1)
        begin
            takes++;
            last_take = take;
        end
        if (err_event === 1'b1)
            errs++;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= (w != 0);
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic msg(input logic [15:0] s, input logic [3:0] len, input logic [3:0] seg,
                       input logic [1:0] mb, input logic [1:0] lt, input int stall,
                       input logic [3:0] st);
        srxm_rsp_t q;
        ep.send('{src_id: s, msglen: len, seg: seg, mbox: mb, letter: lt}, stall, q);
        chk({28'h0, q.status}, {28'h0, st});
        chk({28'h0, q.ftype}, {28'h0, SRXM_FTYPE_RESP});
        chk({16'h0, q.src_id}, {16'h0, s});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        apb(0, 12'h800, 0); chk(rd, 32'hff000000);
        apb(0, 12'h804, 0); chk(rd, 32'h00000100);
        apb(1, 12'h8fc, 32'hffffffff);
        apb(0, 12'h8fc, 0); chk(rd, 32'h0000033f);
        apb(0, 12'h700, 0); chk({31'h0, slv}, 32'h1);
    endtask

    task automatic t_src;
        msg(16'h0005, 4'h0, 4'h0, 2'h0, 2'h0, 0, SRXM_ST_ERROR);
        apb(0, SRXM_STAT_ADDR, 0); chk(rd & 32'h1, 32'h1);
        chk(errs, 1);
        apb(0, SRXM_CAP_ADDR, 0); chk(rd, 32'h00000005);
        apb(1, SRXM_STAT_ADDR, 32'h7);
        msg(16'h0005, 4'h0, 4'h0, 2'h1, 2'h0, 0, SRXM_ST_ERROR);
        apb(0, SRXM_STAT_ADDR, 0); chk(rd, 32'h4);
        msg(16'h0000, 4'h0, 4'h0, 2'h0, 2'h0, 0, SRXM_ST_ERROR);
        @(posedge pclk);
        chk(errs, 1);
    endtask

    task automatic t_single;
        apb(1, 12'h808, 32'h0);
        apb(1, 12'h80c, 32'h0000000a);
        apb(1, 12'h608, 32'h00001000);
        msg(16'h0000, 4'h0, 4'h1, 2'h0, 2'h0, 0, SRXM_ST_DONE);
        msg(16'h0000, 4'h0, 4'h0, 2'h0, 2'h0, 0, SRXM_ST_ERROR);
        msg(16'h1234, 4'h0, 4'h5, 2'h3, 2'h1, 0, SRXM_ST_DONE);
        @(posedge pclk);
        chk(takes, 2);
        chk({28'h0, last_take.queue}, 32'h2);
        chk(last_take.ptr, 32'h00001000);
        apb(1, 12'h608, 32'h00002000);
        apb(0, 12'h608, 0); chk(rd, 32'h00001000);
        apb(0, SRXM_STAT_ADDR, 0); chk(rd & 32'h2, 32'h2);
        @(posedge pclk);
        exh_valid <= 1'b1;
        exh_queue <= 4'h2;
        @(posedge pclk);
        exh_valid <= 1'b0;
        apb(0, 12'h608, 0); chk(rd, 32'h0);
        msg(16'h1234, 4'h0, 4'h5, 2'h3, 2'h1, 0, SRXM_ST_ERROR);
    endtask

    task automatic t_multi;
        apb(1, 12'h810, 32'hff810077);
        apb(1, 12'h814, 32'h00000011);
        apb(1, 12'h818, 32'hffc10077);
        apb(1, 12'h81c, 32'h00000011);
        apb(1, 12'h610, 32'h00004000);
        msg(16'h0077, 4'h2, 4'h0, 2'h1, 2'h2, 0, SRXM_ST_DONE);
        apb(0, SRXM_BUSY_ADDR, 0); chk(rd, 32'h10);
        msg(16'h0077, 4'h2, 4'h0, 2'h1, 2'h3, 0, SRXM_ST_RETRY);
        msg(16'h0077, 4'h2, 4'h0, 2'h1, 2'h2, 0, SRXM_ST_ERROR);
        msg(16'h0077, 4'h2, 4'h1, 2'h1, 2'h2, 3, SRXM_ST_DONE);
        msg(16'h0077, 4'h2, 4'h2, 2'h1, 2'h2, 0, SRXM_ST_DONE);
        apb(0, SRXM_BUSY_ADDR, 0); chk(rd, 32'h0);
        chk(takes, 3);
        chk(last_take.ptr, 32'h00004000);
        msg(16'h0077, 4'h2, 4'h0, 2'h1, 2'h2, 0, SRXM_ST_DONE);
        @(posedge pclk);
        rel_valid <= 1'b1;
        rel_queue <= 4'h4;
        @(posedge pclk);
        rel_valid <= 1'b0;
        apb(0, SRXM_BUSY_ADDR, 0); chk(rd, 32'h0);
    endtask

    task automatic summarize;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #(40 * 20000);
        error_cnt++;
        summarize();
    end

    // Table programmed after the one reset release, 10 cycles in
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_src();
        t_single();
        t_multi();
        summarize();
    end
endmodule

`default_nettype wire
